// ==== design/pgs_pkg.sv ====
/*
 * constants shared by the paired converter output and gain sync block.
 * assumes a single input sampling clock; serial configuration pins are asynchronous.
 */
package pgs_pkg;
	localparam int NCONV        = 8;
	localparam int NCH          = 16;
	localparam int WORD_W       = 12;
	localparam int LATENCY      = 11;
	localparam int FRAME_HI     = 6;
	localparam int GAIN_W       = 9;
	localparam logic [8:0] GAIN_MAX = 9'h120; // 288 steps of 0.125 dB above -5 dB
	localparam int CURVE_DEPTH  = 32;
	localparam int CLK_NS       = 40;
	localparam int STEP_NS      = 1000;
	localparam int STEP_CYC     = (STEP_NS / CLK_NS < 1) ? 1 : STEP_NS / CLK_NS;
	localparam int CFG_W        = 24;
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_ANLG  = 8'h03;
	localparam logic [7:0] ADDR_GAIN0 = 8'h01;
	localparam logic [7:0] ADDR_CURV0 = 8'h20;
	localparam int BIT_SWRST    = 0;
	localparam int BIT_CURVE_WR = 2;
	localparam int BIT_SWSYNC   = 3;
	localparam int BIT_CLAMP    = 2;
	localparam logic [1:0] AAF_7M5 = 2'h0;
	localparam logic [1:0] AAF_10M = 2'h1;
	localparam logic [1:0] AAF_14M = 2'h2;
endpackage : pgs_pkg

// ==== design/pgs_lane_ser.sv ====
/*
 * one serial output lane: loads a word and shifts it out msb first.
 * assumes load and shift strobes come from the shared bit timing.
 */
`timescale 1ns/1ps
`default_nettype none
module pgs_lane_ser #(
	parameter int W = 12
) (
	input  wire logic         clk_i,
	input  wire logic         clr_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] word_i,
	input  wire logic         shift_i,
	output logic              bit_o
);
	logic [W-1:0] sh_r;

	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			sh_r <= '0;
		end else if (load_i) begin
			sh_r <= word_i;
		end else if (shift_i) begin
			sh_r <= {sh_r[W-2:0], 1'b0};
		end
	end

	assign bit_o = sh_r[W-1];
endmodule : pgs_lane_ser
`default_nettype wire

// ==== design/pgs_top.sv ====
/*
 * digital side of the paired converter front end: latency pipeline, lane serialisers,
 * bit and frame clocks, serial configuration, per channel gain and curve stepping.
 * assumes conv_code_i comes from the converters on clk_i and sys_rst_i is synchronous to clk_i; all other inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module pgs_top
	import pgs_pkg::*;
#(
	parameter int STEP_CYCLES = STEP_CYC
) (
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic [NCONV*WORD_W-1:0] conv_code_i,
	input  wire logic                    hw_sync_i,
	input  wire logic                    serial_clk_i,
	input  wire logic                    serial_select_n_i,
	input  wire logic                    serial_shift_data_i,
	output logic [NCH-1:0]               lane_data_o,
	output logic                         bit_clk_o,
	output logic                         frame_clk_o,
	output logic [NCH*GAIN_W-1:0]        chan_gain_o,
	output logic [1:0]                   antialias_filter_select_o,
	output logic                         clamp_en_o,
	output logic                         curve_running_o,
	output logic                         sample_phase_o
);
	// synchronisers: 0 sync, 1 sclk, 2 select_n, 3 data
	logic [3:0]              s1_r;
	logic [3:0]              s2_r;
	logic                    sclk_d_r;
	logic                    sync_d_r;
	logic                    soft_rst_r;
	logic                    clr;
	// converter side
	logic                    phase_r;
	logic [NCONV*WORD_W-1:0] pipe_r [LATENCY];
	logic                    pipe_ph_r [LATENCY];
	logic [WORD_W-1:0]       res_r [NCH];
	// output timing
	logic                    bitph_r;
	logic [3:0]              bit_cnt_r;
	logic [3:0]              bit_cnt_nxt;
	logic                    bit_clk_r;
	logic                    frame_clk_r;
	logic                    adv;
	logic                    lane_load;
	logic                    lane_shift;
	// configuration
	logic [CFG_W-1:0]        cfg_sh_r;
	logic [4:0]              cfg_cnt_r;
	logic                    sclk_rise;
	logic                    commit;
	logic [CFG_W-1:0]        cfg_word;
	logic [7:0]              cfg_addr;
	logic [15:0]             cfg_data;
	logic                    curve_wr_r;
	logic [1:0]              aaf_r;
	logic                    clamp_r;
	logic [GAIN_W-1:0]       gain_r [NCH];
	logic [GAIN_W-1:0]       curve_r [CURVE_DEPTH];
	logic [GAIN_W-1:0]       wr_gain;
	logic                    wr_ctrl;
	logic                    wr_anlg;
	logic                    wr_gain_bank;
	logic                    wr_curve_bank;
	logic [7:0]              gain_idx;
	logic [7:0]              curve_idx;
	// curve stepping
	logic                    hw_sync_rise;
	logic                    sw_sync;
	logic                    start;
	logic                    running_r;
	logic [4:0]              step_idx_r;
	logic [15:0]             step_cnt_r;
	logic [GAIN_W-1:0]       gain_out_r [NCH];

	assign clr = sys_rst_i | soft_rst_r;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			// idle levels: select_n high, clocks and data low
			s1_r     <= 4'h4;
			s2_r     <= 4'h4;
			sclk_d_r <= 1'b0;
			sync_d_r <= 1'b0;
		end else begin
			s1_r     <= {serial_shift_data_i, serial_select_n_i, serial_clk_i, hw_sync_i};
			s2_r     <= s1_r;
			sclk_d_r <= s2_r[1];
			sync_d_r <= s2_r[0];
		end
	end

	assign hw_sync_rise = s2_r[0] & ~sync_d_r;
	assign sclk_rise    = s2_r[1] & ~sclk_d_r & ~s2_r[2];

	// converter pipeline: even channel on phase 0, odd channel on phase 1
	// sample stream restarts only on the reset pin; a soft reset never cuts a frame
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			phase_r <= 1'b0;
			for (int i = 0; i < LATENCY; i++) begin
				pipe_r[i]    <= '0;
				pipe_ph_r[i] <= 1'b0;
			end
			for (int c = 0; c < NCH; c++) begin
				res_r[c] <= '0;
			end
		end else begin
			phase_r      <= ~phase_r;
			pipe_r[0]    <= conv_code_i;
			pipe_ph_r[0] <= phase_r;
			for (int i = 1; i < LATENCY; i++) begin
				pipe_r[i]    <= pipe_r[i-1];
				pipe_ph_r[i] <= pipe_ph_r[i-1];
			end
			for (int k = 0; k < NCONV; k++) begin
				// two's complement to straight offset binary
				res_r[2*k + int'(pipe_ph_r[LATENCY-1])] <=
					pipe_r[LATENCY-1][k*WORD_W +: WORD_W] ^ {1'b1, {(WORD_W-1){1'b0}}};
			end
		end
	end

	// two clocks per bit; bit clock rises mid bit
	assign adv         = bitph_r;
	assign bit_cnt_nxt = (bit_cnt_r == 4'(WORD_W-1)) ? 4'h0 : bit_cnt_r + 4'h1;
	assign lane_load   = adv & (bit_cnt_r == 4'(WORD_W-1));
	assign lane_shift  = adv & ~lane_load;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bitph_r     <= 1'b0;
			bit_cnt_r   <= 4'(WORD_W-1);
			bit_clk_r   <= 1'b0;
			frame_clk_r <= 1'b0;
		end else begin
			bitph_r   <= ~bitph_r;
			bit_clk_r <= ~bitph_r;
			if (adv) begin
				bit_cnt_r   <= bit_cnt_nxt;
				frame_clk_r <= (bit_cnt_nxt < 4'(FRAME_HI));
			end
		end
	end

	for (genvar c = 0; c < NCH; c++) begin : g_lane
		pgs_lane_ser #(.W(WORD_W)) u_lane (
			.clk_i   (clk_i),
			.clr_i   (sys_rst_i),
			.load_i  (lane_load),
			.word_i  (res_r[c]),
			.shift_i (lane_shift),
			.bit_o   (lane_data_o[c])
		);
	end

	// serial configuration word capture
	assign cfg_word      = {cfg_sh_r[CFG_W-2:0], s2_r[3]};
	assign commit        = sclk_rise & (cfg_cnt_r == 5'(CFG_W-1));
	assign cfg_addr      = cfg_word[23:16];
	assign cfg_data      = cfg_word[15:0];
	assign wr_ctrl       = commit & (cfg_addr == ADDR_CTRL);
	assign wr_anlg       = commit & ~curve_wr_r & (cfg_addr == ADDR_ANLG);
	assign gain_idx      = cfg_addr - ADDR_GAIN0;
	assign curve_idx     = cfg_addr - ADDR_CURV0;
	assign wr_gain_bank  = commit & curve_wr_r & (cfg_addr >= ADDR_GAIN0) &
		(gain_idx < 8'(NCH));
	assign wr_curve_bank = commit & curve_wr_r & (cfg_addr >= ADDR_CURV0) &
		(curve_idx < 8'(CURVE_DEPTH));
	assign wr_gain       = (cfg_data[GAIN_W-1:0] > GAIN_MAX) ? GAIN_MAX
		: cfg_data[GAIN_W-1:0];
	assign sw_sync       = wr_ctrl & cfg_data[BIT_SWSYNC];
	assign start         = hw_sync_rise | sw_sync;

	always_ff @(posedge clk_i) begin
		if (clr) begin
			cfg_sh_r   <= '0;
			cfg_cnt_r  <= '0;
			curve_wr_r <= 1'b0;
			aaf_r      <= AAF_7M5;
			clamp_r    <= 1'b0;
			soft_rst_r <= 1'b0;
			for (int c = 0; c < NCH; c++) begin
				gain_r[c] <= '0;
			end
			for (int j = 0; j < CURVE_DEPTH; j++) begin
				curve_r[j] <= '0;
			end
		end else begin
			if (s2_r[2]) begin
				cfg_cnt_r <= '0;
			end else if (sclk_rise) begin
				cfg_sh_r  <= cfg_word;
				cfg_cnt_r <= commit ? 5'h00 : cfg_cnt_r + 5'h01;
			end
			if (wr_ctrl) begin
				curve_wr_r <= cfg_data[BIT_CURVE_WR];
				soft_rst_r <= cfg_data[BIT_SWRST];
			end
			if (wr_anlg) begin
				aaf_r   <= cfg_data[1:0];
				clamp_r <= cfg_data[BIT_CLAMP];
			end
			if (wr_gain_bank) begin
				gain_r[gain_idx[3:0]] <= wr_gain;
			end
			if (wr_curve_bank) begin
				curve_r[curve_idx[4:0]] <= wr_gain;
			end
		end
	end

	// curve stepping: one shared index for every channel, holds on the last entry
	always_ff @(posedge clk_i) begin
		if (clr) begin
			running_r  <= 1'b0;
			step_idx_r <= '0;
			step_cnt_r <= '0;
			for (int c = 0; c < NCH; c++) begin
				gain_out_r[c] <= '0;
			end
		end else begin
			if (start) begin
				running_r  <= 1'b1;
				step_idx_r <= '0;
				step_cnt_r <= '0;
			end else if (running_r) begin
				if (step_cnt_r == 16'(STEP_CYCLES - 1)) begin
					step_cnt_r <= '0;
					if (step_idx_r != 5'(CURVE_DEPTH - 1)) begin
						step_idx_r <= step_idx_r + 5'h01;
					end
				end else begin
					step_cnt_r <= step_cnt_r + 16'h0001;
				end
			end
			for (int c = 0; c < NCH; c++) begin
				gain_out_r[c] <= running_r ? curve_r[step_idx_r] : gain_r[c];
			end
		end
	end

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			chan_gain_o[c*GAIN_W +: GAIN_W] = gain_out_r[c];
		end
	end

	assign bit_clk_o                 = bit_clk_r;
	assign frame_clk_o               = frame_clk_r;
	assign antialias_filter_select_o = aaf_r;
	assign clamp_en_o                = clamp_r;
	assign curve_running_o           = running_r;
	assign sample_phase_o            = phase_r;
endmodule : pgs_top
`default_nettype wire

// ==== tb/pgs_rx_cap.sv ====
/*
 * capture receiver model for the serial lanes.
 * assumes bit and frame clocks come from flops on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pgs_rx_cap (
	input  wire logic        clk_i,
	input  wire logic        bit_clk_i,
	input  wire logic        frame_i,
	input  wire logic [15:0] lane_i,
	output logic      [11:0] word_o [16],
	output int               words_o
);
	logic        bp = 1'b0;
	logic        fp = 1'b1;
	int          n = 0;
	logic [11:0] sh [16];
	initial words_o = 0;
	always @(posedge clk_i) bp <= bit_clk_i;
	// bits taken at bit clock rise, word restarts at frame rise
	always @(posedge clk_i) if (bit_clk_i && !bp) begin
		n = (frame_i && !fp) ? 1 : n + 1;
		fp = frame_i;
		for (int c = 0; c < 16; c++) begin
			sh[c] = {sh[c][10:0], lane_i[c]};
			if (n == 12) word_o[c] = sh[c];
		end
		if (n == 12) words_o++;
	end
endmodule : pgs_rx_cap
`default_nettype wire

// ==== tb/pgs_top_props.sv ====
/*
 * assertions on the pgs_top ports.
 * assumes one clock domain and synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pgs_top_props
	import pgs_pkg::*;
#(
	parameter int STEP_CYCLES = STEP_CYC
) (
	input wire logic                    clk_i,
	input wire logic                    sys_rst_i,
	input wire logic                    hw_sync_i,
	input wire logic [NCH-1:0]          lane_data_o,
	input wire logic                    bit_clk_o,
	input wire logic                    frame_clk_o,
	input wire logic [NCH*GAIN_W-1:0]   chan_gain_o,
	input wire logic                    curve_running_o,
	input wire logic                    sample_phase_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic gain_over;
	always_comb begin
		gain_over = 1'b0;
		for (int c = 0; c < NCH; c++)
			gain_over |= chan_gain_o[c*GAIN_W +: GAIN_W] > GAIN_MAX;
	end
	chk_phase_alt: assert property (
		!$past(sys_rst_i) |-> sample_phase_o != $past(sample_phase_o))
		else $error("pair phase did not alternate");
	chk_bit_clk: assert property (
		$rose(bit_clk_o) |=> $fell(bit_clk_o) ##1 $rose(bit_clk_o))
		else $error("bit clock period wrong");
	chk_frame_high: assert property (
		$rose(frame_clk_o) |=> frame_clk_o [*8] ##4 $fell(frame_clk_o))
		else $error("frame high time wrong");
	chk_frame_period: assert property (
		$fell(frame_clk_o) |-> ##12 $rose(frame_clk_o))
		else $error("frame low time wrong");
	chk_frame_edge: assert property (
		$rose(frame_clk_o) |-> !bit_clk_o)
		else $error("frame not on bit start");
	chk_lane_hold: assert property (
		bit_clk_o |-> $stable(lane_data_o))
		else $error("lane moved in bit clock high");
	chk_gain_max: assert property (
		!gain_over)
		else $error("gain code above maximum");
	chk_sync_start: assert property (
		$rose(hw_sync_i) && !curve_running_o |-> ##[1:6] curve_running_o)
		else $error("sync did not start curve");
	chk_reset_clear: assert property (
		$fell(sys_rst_i) |-> chan_gain_o == '0 && !curve_running_o && lane_data_o == '0)
		else $error("reset left state");
endmodule : pgs_top_props
bind pgs_top pgs_top_props #(.STEP_CYCLES(STEP_CYCLES)) u_pgs_top_props (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hw_sync_i(hw_sync_i),
	.lane_data_o(lane_data_o), .bit_clk_o(bit_clk_o), .frame_clk_o(frame_clk_o),
	.chan_gain_o(chan_gain_o), .curve_running_o(curve_running_o),
	.sample_phase_o(sample_phase_o));
`default_nettype wire

// ==== tb/pgs_top_tb.sv ====
/*
 * self checking bench for pgs_top.
 * assumes pgs_rx_cap on the lanes and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module pgs_top_tb;
	import pgs_pkg::*;
	logic        clk_i, sys_rst_i, hw_sync_i, sclk, ssn, sdat;
	logic [95:0] code = '0;
	wire  [15:0] lane;
	wire         bclk, fclk, run, ph, clamp;
	wire [143:0] gain;
	wire  [1:0]  aaf;
	logic [11:0] word [16];
	int          words, n_errors, samples_checked;
	pgs_top #(.STEP_CYCLES(8)) u_pgs_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.conv_code_i(code), .hw_sync_i(hw_sync_i), .serial_clk_i(sclk),
		.serial_select_n_i(ssn), .serial_shift_data_i(sdat), .lane_data_o(lane),
		.bit_clk_o(bclk), .frame_clk_o(fclk), .chan_gain_o(gain),
		.antialias_filter_select_o(aaf), .clamp_en_o(clamp),
		.curve_running_o(run), .sample_phase_o(ph));
	pgs_rx_cap u_pgs_rx_cap (.clk_i(clk_i), .bit_clk_i(bclk), .frame_i(fclk),
		.lane_i(lane), .word_o(word), .words_o(words));
	initial begin
		clk_i = 0;
		forever #20 clk_i = ~clk_i;
	end
	// even and odd channel codes differ per converter
	always @(posedge clk_i) begin
		#2;
		for (int k = 0; k < NCONV; k++)
			code[k*12 +: 12] <= ph ? 12'hA40 + 12'(k) : 12'h120 + 12'(k);
	end
	task automatic cy(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : cy
	task automatic ck(input logic [159:0] g, input logic [159:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %0t %h %h", $time, g, e);
		end
	endtask : ck
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [23:0] w;
		w = {a, d};
		ssn = 0;
		for (int i = 23; i >= 0; i--) begin
			sdat = w[i];
			cy(4);
			sclk = 1;
			cy(4);
			sclk = 0;
		end
		cy(4);
		ssn = 1;
		sdat = 0;
		cy(8);
	endtask : wr
	task automatic wait_run;
		int i;
		for (i = 0; i < 20 && run !== 1'b1; i++) cy(1);
		if (i == 20) begin
			n_errors++;
			close_out();
		end
	endtask : wait_run
	task automatic t_lanes;
		cy(100);
		ck(words >= 3, 1'b1);
		for (int c = 0; c < 16; c++)
			ck(word[c], ((c % 2 ? 12'hA40 : 12'h120) + 12'(c / 2)) ^ 12'h800);
	endtask : t_lanes
	task automatic t_gain;
		wr(8'h00, 16'h0004);
		wr(8'h04, 16'h0050);
		wr(8'h06, 16'h01FF);
		ck(gain[27 +: 9], 9'h050);
		ck(gain[45 +: 9], GAIN_MAX);
	endtask : t_gain
	task automatic t_curve;
		wr(8'h20, 16'h0011);
		wr(8'h3F, 16'h00AB);
		hw_sync_i = 1;
		wait_run();
		cy(1);
		ck(gain, {16{9'h011}});
		cy(300);
		ck({run, gain}, {1'b1, {16{9'h0AB}}});
		hw_sync_i = 0;
	endtask : t_curve
	task automatic t_soft;
		wr(8'h00, 16'h0001);
		ck({run, clamp, aaf, gain}, '0);
		wr(8'h00, 16'h0008);
		wait_run();
		ck(run, 1'b1);
	endtask : t_soft
	task automatic t_aaf;
		for (int f = 0; f < 3; f++) begin
			wr(8'h03, 16'(f) | (f == 1 ? 16'h0004 : 16'h0000));
			ck({clamp, aaf}, {f == 1, 2'(f)});
		end
	endtask : t_aaf
	initial begin
		sys_rst_i = 1;
		hw_sync_i = 0;
		sclk = 0;
		ssn = 1;
		sdat = 0;
		cy(12);
		sys_rst_i = 0;
		cy(1);
		ck({run, clamp, aaf, gain}, '0);
		t_lanes();
		t_gain();
		t_curve();
		t_soft();
		t_aaf();
		close_out();
	end
endmodule : pgs_top_tb
`default_nettype wire
